// ===== design/wdidle_pkg.sv
// Constants for the watchdog and idle-mode control block
package wdidle_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the special function register bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DEEP_SLEEP_CONTROL       = 8'h87;
  localparam logic [7:0] ADDR_WATCHDOG_TIMEOUT_SELECT  = 8'h91;
  localparam logic [7:0] ADDR_WATCHDOG_RUN_CONTROL     = 8'h92;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_CONFIG      = 8'had;
  localparam logic [7:0] ADDR_RESET_CAUSE              = 8'h0f;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int         LIGHT_SLEEP_BIT      = 4;
  localparam int         DEEP_SLEEP_BIT       = 0;
  localparam int         WDT_RESET_FLAG_BIT   = 0;
  localparam int         POWER_ON_FLAG_BIT    = 1;
  localparam logic [7:0] WDT_STOP_CODE        = 8'h55;
  localparam logic [7:0] TIMEOUT_SEL_RESET    = 8'h00;
  localparam logic [7:0] RUN_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] CLOCK_CONFIG_RESET   = 8'h08;
  localparam logic [7:0] DEEP_SLEEP_RESET     = 8'h00;
  localparam logic [7:0] RESET_CAUSE_POWER_ON = 8'h02;
  localparam logic [7:0] READ_NONE            = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_HZ      = 25_000_000;
  localparam int LOW_OSC_HZ      = 32_000;
  localparam int BASE_TICK_MS    = 18;
  localparam int RESET_HOLD_MS   = 20;
  localparam int WAKE_DELAY_US   = 100;
  // Base tick in low-speed oscillator cycles, rounded down
  localparam int BASE_TICK_OSC   = LOW_OSC_HZ / 1000 * BASE_TICK_MS;
  // Reset hold counted on the system clock, rounded down
  localparam int RESET_HOLD_CYC  = (SYS_CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int WAKE_DELAY_CYC  = (SYS_CLK_HZ / 1_000_000) * WAKE_DELAY_US;
  localparam int OSC_DIV_CYC     = (SYS_CLK_HZ + LOW_OSC_HZ - 1) / LOW_OSC_HZ;

  // ----------------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } wdidle_state_t;

endpackage

// ===== design/wdidle_top.sv
// Watchdog timer with light and deep idle-mode control
`timescale 1ns/1ns
module wdidle_top #(
  parameter int RESET_HOLD_CYCLES = wdidle_pkg::RESET_HOLD_CYC,
  parameter int BASE_TICK_COUNT   = wdidle_pkg::BASE_TICK_OSC,
  parameter int OSC_DIV           = wdidle_pkg::OSC_DIV_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        low_speed_osc_tick_in,
  input  wire logic        use_osc_tick_in,
  input  wire logic [10:0] light_wake_irq_in,
  input  wire logic        timer2_irq_in,
  input  wire logic        lcd_irq_in,
  input  wire logic        wdt_irq_enable_in,
  input  wire logic        return_from_interrupt_in,
  output logic      [7:0]  sfr_rdata_out,
  output logic             global_reset_n_out,
  output logic             watchdog_irq_out,
  output logic             light_sleep_out,
  output logic             deep_sleep_out,
  output logic             core_halt_out,
  output logic             wake_pulse_out,
  output logic             wake_settling_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                timeout_sel;
    logic [7:0]                run_ctrl;
    logic [7:0]                clk_cfg;
    logic [7:0]                deep_ctl;
    logic [7:0]                reset_cause;
    logic [7:0]                rdata;
    logic [15:0]               osc_div;
    logic                      osc_tick;
    logic [1:0]                clr_sync;
    logic [15:0]               prescale;
    logic [7:0]                tick_cnt;
    logic [31:0]               hold_cnt;
    wdidle_pkg::wdidle_state_t state;
    logic                      rst_n;
    logic                      wdt_irq;
    logic                      wake;
    logic [15:0]               settle_cnt;
    logic                      halt;
    logic                      settling;
  } wdidle_state_s_t;

  // ----------------------------------------------------------------------
  // Timing notes
  // ----------------------------------------------------------------------
  // The watchdog time base is the low-speed oscillator tick. It is a
  // one-cycle enable pulse on the system clock, so the whole block stays
  // in one clock domain.
  // The counter clear is applied at once but released only after two
  // oscillator ticks. A timeout can therefore run up to two ticks longer.
  // Writes are ignored while the global reset is held low. A watchdog
  // reset cannot be cut short by software.
  // Every output is registered. The idle-halt and settling flags are kept
  // as their own state bits for that reason.

  wdidle_state_s_t s_reg;
  wdidle_state_s_t s_next;

  logic       wdt_enabled;
  logic       deep_mode;
  logic       tick;
  logic [7:0] limit;
  logic       overflow;

  always_comb begin
    wdt_enabled = (s_reg.run_ctrl != wdidle_pkg::WDT_STOP_CODE);
    deep_mode   = s_reg.deep_ctl[wdidle_pkg::DEEP_SLEEP_BIT];
    tick        = use_osc_tick_in ? low_speed_osc_tick_in : s_reg.osc_tick;
    limit       = 8'h01 << s_reg.timeout_sel[2:0];
    overflow    = 1'b0;
    s_next      = s_reg;
    s_next.wake = 1'b0;

    // --------------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------------
    if (sfr_wr_in && s_reg.rst_n) begin
      if (sfr_addr_in == wdidle_pkg::ADDR_WATCHDOG_TIMEOUT_SELECT) begin
        s_next.timeout_sel = sfr_wdata_in;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_WATCHDOG_RUN_CONTROL) begin
        s_next.run_ctrl = sfr_wdata_in;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_SYSTEM_CLOCK_CONFIG) begin
        s_next.clk_cfg = sfr_wdata_in;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_DEEP_SLEEP_CONTROL) begin
        s_next.deep_ctl = {7'h00, sfr_wdata_in[wdidle_pkg::DEEP_SLEEP_BIT]};
      end else if (sfr_addr_in == wdidle_pkg::ADDR_RESET_CAUSE) begin
        s_next.reset_cause = sfr_wdata_in;
      end
    end

    // --------------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------------
    if (sfr_rd_in) begin
      if (sfr_addr_in == wdidle_pkg::ADDR_WATCHDOG_TIMEOUT_SELECT) begin
        s_next.rdata = s_reg.timeout_sel;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_WATCHDOG_RUN_CONTROL) begin
        s_next.rdata = s_reg.run_ctrl;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_SYSTEM_CLOCK_CONFIG) begin
        s_next.rdata = s_reg.clk_cfg;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_DEEP_SLEEP_CONTROL) begin
        s_next.rdata = s_reg.deep_ctl;
      end else if (sfr_addr_in == wdidle_pkg::ADDR_RESET_CAUSE) begin
        s_next.rdata = s_reg.reset_cause;
      end else begin
        s_next.rdata = wdidle_pkg::READ_NONE;
      end
    end

    // --------------------------------------------------------------------
    // Internal oscillator divider, used when no external tick is given
    // --------------------------------------------------------------------
    if (s_reg.osc_div >= 16'(OSC_DIV - 1)) begin
      s_next.osc_div  = 16'h0000;
      s_next.osc_tick = 1'b1;
    end else begin
      s_next.osc_div  = s_reg.osc_div + 16'h0001;
      s_next.osc_tick = 1'b0;
    end

    // --------------------------------------------------------------------
    // Counter clear: held until the second oscillator tick releases it
    // --------------------------------------------------------------------
    // Reset or write clear
    if (!s_reg.rst_n ||
        (sfr_wr_in && sfr_addr_in == wdidle_pkg::ADDR_WATCHDOG_TIMEOUT_SELECT)) begin
      s_next.clr_sync = 2'b11;
    end else if (tick) begin
      s_next.clr_sync = {s_reg.clr_sync[0], 1'b0};
    end

    // --------------------------------------------------------------------
    // Watchdog counter
    // --------------------------------------------------------------------
    if (s_reg.clr_sync[1] || s_next.clr_sync[1]) begin
      s_next.prescale = 16'h0000;
      s_next.tick_cnt = 8'h00;
    end else if (wdt_enabled && tick) begin
      if (s_reg.prescale >= 16'(BASE_TICK_COUNT - 1)) begin
        s_next.prescale = 16'h0000;
        if (s_reg.tick_cnt + 8'h01 >= limit) begin
          overflow        = 1'b1;
          s_next.tick_cnt = 8'h00;
        end else begin
          s_next.tick_cnt = s_reg.tick_cnt + 8'h01;
        end
      end else begin
        s_next.prescale = s_reg.prescale + 16'h0001;
      end
    end

    // --------------------------------------------------------------------
    // Overflow handling and reset sequencing
    // --------------------------------------------------------------------
    case (s_reg.state)
      wdidle_pkg::ST_RUN: begin
        s_next.rst_n = 1'b1;
        if (overflow && !deep_mode) begin
          s_next.state    = wdidle_pkg::ST_HOLD;
          s_next.rst_n    = 1'b0;
          s_next.hold_cnt = 32'h0000_0000;
          s_next.reset_cause[wdidle_pkg::WDT_RESET_FLAG_BIT] = 1'b1;
        end
      end
      wdidle_pkg::ST_HOLD: begin
        s_next.rst_n = 1'b0;
        if (s_reg.hold_cnt >= 32'(RESET_HOLD_CYCLES - 1)) begin
          s_next.state       = wdidle_pkg::ST_RUN;
          s_next.rst_n       = 1'b1;
          // Configuration reloads to defaults; watchdog runs again
          s_next.timeout_sel = wdidle_pkg::TIMEOUT_SEL_RESET;
          s_next.run_ctrl    = wdidle_pkg::RUN_CONTROL_RESET;
          s_next.clk_cfg     = wdidle_pkg::CLOCK_CONFIG_RESET;
          s_next.deep_ctl    = wdidle_pkg::DEEP_SLEEP_RESET;
          s_next.wdt_irq     = 1'b0;
        end else begin
          s_next.hold_cnt = s_reg.hold_cnt + 32'h0000_0001;
        end
      end
      default: begin
        s_next.state = wdidle_pkg::ST_HOLD;
        s_next.rst_n = 1'b0;
      end
    endcase

    if (overflow && deep_mode) begin
      s_next.wdt_irq = 1'b1;
    end else if (return_from_interrupt_in) begin
      s_next.wdt_irq = 1'b0;
    end

    // --------------------------------------------------------------------
    // Wake-up from idle modes
    // --------------------------------------------------------------------
    // Deep idle wake sources only
    if (deep_mode && ((s_next.wdt_irq && wdt_irq_enable_in) || timer2_irq_in || lcd_irq_in)) begin
      s_next.deep_ctl[wdidle_pkg::DEEP_SLEEP_BIT] = 1'b0;
      s_next.wake       = 1'b1;
      s_next.settle_cnt = 16'(wdidle_pkg::WAKE_DELAY_CYC);
    end else if (s_reg.settle_cnt != 16'h0000) begin
      s_next.settle_cnt = s_reg.settle_cnt - 16'h0001;
    end
    if (s_reg.clk_cfg[wdidle_pkg::LIGHT_SLEEP_BIT] &&
        ((|light_wake_irq_in) || (s_next.wdt_irq && wdt_irq_enable_in))) begin
      s_next.clk_cfg[wdidle_pkg::LIGHT_SLEEP_BIT] = 1'b0;
      s_next.wake = 1'b1;
    end

    // --------------------------------------------------------------------
    // Registered status outputs
    // --------------------------------------------------------------------
    // Built from the next state so that the flops match the idle bits
    s_next.halt     = s_next.clk_cfg[wdidle_pkg::LIGHT_SLEEP_BIT] |
                      s_next.deep_ctl[wdidle_pkg::DEEP_SLEEP_BIT];
    s_next.settling = (s_next.settle_cnt != 16'h0000);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg             <= '0;
      s_reg.timeout_sel <= wdidle_pkg::TIMEOUT_SEL_RESET;
      s_reg.run_ctrl    <= wdidle_pkg::RUN_CONTROL_RESET;
      s_reg.clk_cfg     <= wdidle_pkg::CLOCK_CONFIG_RESET;
      s_reg.deep_ctl    <= wdidle_pkg::DEEP_SLEEP_RESET;
      s_reg.reset_cause <= wdidle_pkg::RESET_CAUSE_POWER_ON;
      s_reg.clr_sync    <= 2'b11;
      s_reg.state       <= wdidle_pkg::ST_RUN;
      s_reg.rst_n       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a plain copy of a state bit, with no logic after the flop.

  // Core halts in idle; vectoring and resume are the core's job
  assign sfr_rdata_out      = s_reg.rdata;
  assign global_reset_n_out = s_reg.rst_n;
  assign watchdog_irq_out   = s_reg.wdt_irq;
  assign light_sleep_out    = s_reg.clk_cfg[wdidle_pkg::LIGHT_SLEEP_BIT];
  assign deep_sleep_out     = s_reg.deep_ctl[wdidle_pkg::DEEP_SLEEP_BIT];
  assign core_halt_out      = s_reg.halt;
  assign wake_pulse_out     = s_reg.wake;
  assign wake_settling_out  = s_reg.settling;

endmodule

// ===== sim/tb.sv
// Self-checking bench for the watchdog and idle-mode block
`timescale 1ns/1ns
module tb;
  logic        sys_clk_in, arst_n_in, sfr_wr_in, sfr_rd_in, timer2_irq_in, lcd_irq_in, wdt_irq_enable_in;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d;
  logic [10:0] light_wake_irq_in;
  logic        tick, rfi, grst_n, wdt_irq, light, deep, halt, wake, settling, rd_seen;
  logic [7:0]  exp_q[$];
  int          n_errors, checked, n;
  wdidle_top #(.RESET_HOLD_CYCLES(20), .BASE_TICK_COUNT(2), .OSC_DIV(782)) DUT (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .low_speed_osc_tick_in(tick),
    .use_osc_tick_in(1'b1), .light_wake_irq_in(light_wake_irq_in), .timer2_irq_in(timer2_irq_in),
    .lcd_irq_in(lcd_irq_in), .wdt_irq_enable_in(wdt_irq_enable_in), .return_from_interrupt_in(rfi),
    .sfr_rdata_out(sfr_rdata_out), .global_reset_n_out(grst_n), .watchdog_irq_out(wdt_irq),
    .light_sleep_out(light), .deep_sleep_out(deep), .core_halt_out(halt), .wake_pulse_out(wake),
    .wake_settling_out(settling));
  wdidle_core_model u_core (.sys_clk_in(sys_clk_in), .irq_in(wdt_irq), .settling_in(settling),
    .tick_out(tick), .rfi_out(rfi));
  always #20 sys_clk_in = ~sys_clk_in;
  task automatic conclude();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_val(ref logic s, input logic v, input int bound, output int cnt);
    cnt = 0;
    while (s !== v && cnt < bound) begin
      @(negedge sys_clk_in);
      cnt++;
    end
    check("wait", {7'h00, s}, {7'h00, v});
    if (s !== v) conclude();
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge sys_clk_in);
    sfr_wr_in = 1'b1;
    sfr_addr_in = a;
    sfr_wdata_in = v;
    @(negedge sys_clk_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(negedge sys_clk_in);
    sfr_rd_in = 1'b1;
    sfr_addr_in = a;
    @(negedge sys_clk_in);
    sfr_rd_in = 1'b0;
  endtask
  // Read data lands one cycle after the read strobe
  always @(posedge sys_clk_in) rd_seen <= sfr_rd_in;
  always @(negedge sys_clk_in) if (rd_seen === 1'b1) check("rdata", sfr_rdata_out, exp_q.pop_front());
  initial begin
    {sys_clk_in, arst_n_in, sfr_wr_in, sfr_rd_in, timer2_irq_in, lcd_irq_in, wdt_irq_enable_in} = 7'h00;
    {sfr_addr_in, sfr_wdata_in, light_wake_irq_in, rd_seen} = 28'h000_0000;
    n_errors = 0;
    checked = 0;
    d = 8'($urandom(27046));
    repeat (8) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    wr(8'h91, 8'h07);
    rd(8'h91, 8'h07);
    rd(8'h92, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'had, 8'h08);
    rd(8'h0f, 8'h02);
    rd(8'h33, 8'h00);
    wr(8'h92, 8'h55);
    wr(8'h91, 8'h00);
    repeat (60) @(negedge sys_clk_in);
    check("rst", grst_n, 1'b1);
    d = 8'($urandom);
    if (d == 8'h55) d = 8'h56;
    wr(8'h92, d);
    wait_val(grst_n, 1'b0, 80, n);
    wait_val(grst_n, 1'b1, 60, n);
    rd(8'h91, 8'h00);
    rd(8'h0f, 8'h03);
    for (int i = 0; i < 12; i++) begin
      wr(8'h91, 8'h00);
      check("rst", grst_n, 1'b1);
    end
    // Each step doubles the interval; slack covers clear sync
    for (int k = 0; k < 8; k++) begin
      wait_val(grst_n, 1'b1, 60, n);
      wr(8'h91, 8'(k));
      wait_val(grst_n, 1'b0, (8 << k) + 64, n);
      check("span", 8'(n >= (8 << k) - 8 && n <= (8 << k) + 24), 8'h01);
    end
    wait_val(grst_n, 1'b1, 60, n);
    wr(8'h92, 8'h55);
    for (int i = 0; i < 11; i++) begin
      wr(8'had, 8'h18);
      check("light", {light, halt}, 8'h03);
      light_wake_irq_in = 11'h001 << i;
      wait_val(light, 1'b0, 8, n);
      light_wake_irq_in = 11'h000;
    end
    wr(8'had, 8'h18);
    wr(8'had, 8'h08);
    check("light", {light, halt}, 8'h00);
    wr(8'h87, 8'h01);
    light_wake_irq_in = 11'($urandom) | 11'h001;
    repeat (6) @(negedge sys_clk_in);
    check("deep", deep, 1'b1);
    light_wake_irq_in = 11'h000;
    timer2_irq_in = 1'b1;
    wait_val(deep, 1'b0, 8, n);
    timer2_irq_in = 1'b0;
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h01);
    lcd_irq_in = 1'b1;
    wait_val(deep, 1'b0, 8, n);
    lcd_irq_in = 1'b0;
    wdt_irq_enable_in = 1'b1;
    wr(8'h92, 8'h01);
    wr(8'h91, 8'h00);
    wr(8'h87, 8'h01);
    wait_val(wdt_irq, 1'b1, 80, n);
    wr(8'h92, 8'h55);
    check("wake", {deep, grst_n}, 8'h01);
    wait_val(wdt_irq, 1'b0, 3000, n);
    conclude();
  end
endmodule

// ===== sim/wdidle_core_model.sv
// Core-side model: oscillator tick source and interrupt service return
`timescale 1ns/1ns
module wdidle_core_model (
  input  wire logic sys_clk_in,
  input  wire logic irq_in,
  input  wire logic settling_in,
  output logic      tick_out,
  output logic      rfi_out
);
  logic [1:0] div_reg;
  initial begin
    div_reg  = 2'h0;
    tick_out = 1'b0;
    rfi_out  = 1'b0;
  end
  // Tick every fourth clock keeps timeouts short
  always @(negedge sys_clk_in) begin
    div_reg  <= div_reg + 2'h1;
    tick_out <= (div_reg == 2'h3);
    rfi_out  <= irq_in && !settling_in && !rfi_out;
  end
endmodule

// ===== sim/wdidle_props.sv
// Concurrent checks on the watchdog and idle-mode block ports
`timescale 1ns/1ns
module wdidle_props #(
  parameter int RESET_HOLD_CYCLES = 20
) (
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  input wire logic        sfr_wr_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic [10:0] light_wake_irq_in,
  input wire logic        timer2_irq_in,
  input wire logic        lcd_irq_in,
  input wire logic        wdt_irq_enable_in,
  input wire logic        return_from_interrupt_in,
  input wire logic        global_reset_n_out,
  input wire logic        watchdog_irq_out,
  input wire logic        light_sleep_out,
  input wire logic        deep_sleep_out,
  input wire logic        wake_pulse_out,
  input wire logic        wake_settling_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [7:0] low_cnt_reg;
  logic       deep_src;
  logic       wr_ok;
  assign deep_src = timer2_irq_in || lcd_irq_in;
  assign wr_ok    = sfr_wr_in && global_reset_n_out;
  // Counts low cycles of the global reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_reg <= 8'h00;
    end else if (global_reset_n_out) begin
      low_cnt_reg <= 8'h00;
    end else begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end
  a_hold_length: assert property ($rose(global_reset_n_out) |-> low_cnt_reg == RESET_HOLD_CYCLES)
    else $error("global reset low time wrong");
  a_no_sleep_reset: assert property (deep_sleep_out |=> global_reset_n_out)
    else $error("reset raised in deep idle");
  a_wdt_wake: assert property ($rose(watchdog_irq_out) && wdt_irq_enable_in |-> !deep_sleep_out && wake_pulse_out)
    else $error("watchdog interrupt did not wake");
  a_deep_wake_src: assert property ($fell(deep_sleep_out) |-> watchdog_irq_out || $past(deep_src)
    || $past(wr_ok && sfr_addr_in == wdidle_pkg::ADDR_DEEP_SLEEP_CONTROL))
    else $error("deep idle left without a wake source");
  a_deep_wake_pulse: assert property ($fell(deep_sleep_out) && $past(deep_src) |->
    wake_pulse_out ##[0:1] wake_settling_out)
    else $error("deep wake without pulse or settling");
  a_light_write: assert property (wr_ok && sfr_addr_in == wdidle_pkg::ADDR_SYSTEM_CLOCK_CONFIG
    && light_wake_irq_in == 11'h000 |=> light_sleep_out == $past(sfr_wdata_in[4]))
    else $error("light idle does not follow bit 4");
  a_deep_write: assert property (wr_ok && sfr_addr_in == wdidle_pkg::ADDR_DEEP_SLEEP_CONTROL && !deep_src
    && !wdt_irq_enable_in |=> deep_sleep_out == $past(sfr_wdata_in[0]))
    else $error("deep idle does not follow bit 0");
  a_light_exit: assert property (light_sleep_out && light_wake_irq_in != 11'h000 |-> ##[1:2] !light_sleep_out)
    else $error("light idle kept despite interrupt");
  a_irq_return: assert property (watchdog_irq_out && return_from_interrupt_in && !deep_sleep_out
    |=> !watchdog_irq_out)
    else $error("watchdog interrupt not cleared on return");
  c_reset_end: cover property ($rose(global_reset_n_out));
  c_wdt_wake: cover property ($fell(deep_sleep_out) && watchdog_irq_out);
  c_light_wake: cover property ($fell(light_sleep_out) && wake_pulse_out);
endmodule
bind wdidle_top wdidle_props #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_props (.*);
